// >>> inc/vadj_pkg.sv
/*
 * vadj_pkg: shared constants and types of the video adjust serial slave.
 * Assumes a single system clock domain; bus pins are synchronised inside vadj_top.
 */
package vadj_pkg;

	// ***************************************************************
	// bus addressing
	// ***************************************************************
	localparam logic [6:0] SLAVE_ADDR      = 7'h44;
	localparam logic       DIR_WRITE       = 1'h0;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

	// ***************************************************************
	// subaddress map
	// ***************************************************************
	localparam logic [7:0] CONTROL_OFS     = 8'h00;
	localparam logic [7:0] BRIGHTNESS_OFS  = 8'h01;
	localparam logic [7:0] CONTRAST_OFS    = 8'h02;
	localparam logic [7:0] GAIN_BASE_OFS   = 8'h04;
	localparam logic [7:0] BLACK_BASE_OFS  = 8'h07;
	localparam logic [7:0] WRAP_LAST_OFS   = 8'h09;
	localparam logic [7:0] WRAP_FIRST_OFS  = 8'h00;
	localparam logic [7:0] TEST_OFS        = 8'h0F;

	// ***************************************************************
	// field layout and reset values
	// ***************************************************************
	localparam int         CHANNELS        = 3;
	localparam int         CODE6_W         = 6;
	localparam int         CODE8_W         = 8;
	localparam int         POLARITY_BIT    = 3;
	localparam int         PEDESTAL_BIT    = 0;
	localparam logic [5:0] CODE6_RESET     = 6'h00;
	localparam logic [7:0] CODE8_RESET     = 8'h00;
	localparam logic       CONTROL_RESET   = 1'h0;
	localparam logic [7:0] SUB_RESET       = 8'h00;
	// fixed internal feedback level used with positive polarity
	localparam logic [7:0] FEEDBACK_FIXED  = 8'h80;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_SKIP
	} vadj_state_t;

	typedef enum logic [1:0] {
		BYTE_ADDR,
		BYTE_SUB,
		BYTE_DATA
	} vadj_byte_t;

endpackage

// >>> inc/vadj_wr_if.sv
/*
 * vadj_wr_if: register write strobe passed from the serial engine to the bank.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface vadj_wr_if;
	logic       wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	modport src (
		output wr_stb,
		output wr_addr,
		output wr_data
	);
	modport bank (
		input  wr_stb,
		input  wr_addr,
		input  wr_data
	);
endinterface

// >>> logic/vadj_bank.sv
/*
 * vadj_bank: adjustment register bank written by one-cycle strobes.
 * Assumes strobes come from logic on sys_clk_in; reset is synchronous.
 */
`timescale 1ns/10ps
module vadj_bank (
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_in,
	vadj_wr_if.bank                   wr,
	output logic [5:0]                brightness_out,
	output logic [5:0]                contrast_out,
	output logic [17:0]               gain_out,
	output logic [23:0]               black_ref_out,
	output logic [23:0]               feedback_ref_out,
	output logic                      feedback_polarity_select_out,
	output logic                      pedestal_blank_enable_out
);

	// ***************************************************************
	// decode
	// ***************************************************************
	wire logic hit_control    = wr.wr_stb && (wr.wr_addr == vadj_pkg::CONTROL_OFS);
	wire logic hit_brightness = wr.wr_stb && (wr.wr_addr == vadj_pkg::BRIGHTNESS_OFS);
	wire logic hit_contrast   = wr.wr_stb && (wr.wr_addr == vadj_pkg::CONTRAST_OFS);

	// ***************************************************************
	// shared registers
	// ***************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			feedback_polarity_select_out <= vadj_pkg::CONTROL_RESET;
			pedestal_blank_enable_out    <= vadj_pkg::CONTROL_RESET;
		end else if (hit_control) begin
			feedback_polarity_select_out <= wr.wr_data[vadj_pkg::POLARITY_BIT];
			pedestal_blank_enable_out    <= wr.wr_data[vadj_pkg::PEDESTAL_BIT];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			brightness_out <= vadj_pkg::CODE6_RESET;
			contrast_out   <= vadj_pkg::CODE6_RESET;
		end else begin
			if (hit_brightness)
				brightness_out <= wr.wr_data[5:0];
			if (hit_contrast)
				contrast_out <= wr.wr_data[5:0];
		end
	end

	// ***************************************************************
	// per channel gain, black reference and feedback reference
	// ***************************************************************
	genvar g;
	generate
		for (g = 0; g < vadj_pkg::CHANNELS; g++) begin : g_chan
			wire logic hit_gain  = wr.wr_stb &&
				(wr.wr_addr == vadj_pkg::GAIN_BASE_OFS + 8'(g));
			wire logic hit_black = wr.wr_stb &&
				(wr.wr_addr == vadj_pkg::BLACK_BASE_OFS + 8'(g));
			always_ff @(posedge sys_clk_in) begin
				if (rst_in) begin
					gain_out[6*g +: 6]      <= vadj_pkg::CODE6_RESET;
					black_ref_out[8*g +: 8] <= vadj_pkg::CODE8_RESET;
				end else begin
					if (hit_gain)
						gain_out[6*g +: 6] <= wr.wr_data[5:0];
					if (hit_black)
						black_ref_out[8*g +: 8] <= wr.wr_data;
				end
			end
			// one cycle behind the stored code; pedestal bit is never consulted
			always_ff @(posedge sys_clk_in) begin
				if (rst_in)
					feedback_ref_out[8*g +: 8] <= vadj_pkg::CODE8_RESET;
				else if (feedback_polarity_select_out)
					feedback_ref_out[8*g +: 8] <= vadj_pkg::FEEDBACK_FIXED;
				else
					feedback_ref_out[8*g +: 8] <= black_ref_out[8*g +: 8];
			end
		end
	endgenerate

endmodule

// >>> logic/vadj_top.sv
/*
 * vadj_top: write-only two-wire serial slave with its adjustment bank
 * for a three channel video output stage.
 * Assumes scl, sda and the blanking pins are asynchronous to sys_clk_in
 * and that the bus clock is several times slower than sys_clk_in.
 * Only write frames exist; nothing is ever read back over the bus.
 */
`timescale 1ns/10ps

// How it works
// - Answers only address 1000100 with write direction.
// - Each data byte at subaddress 00H..09H advances the pointer.
// - Pointer at 09H wraps to 00H after a data byte.
// - Above 0FH: bytes acknowledged, no increment, no state change.
// - Any number of data bytes follow one subaddress, auto-incremented.
// - 01H holds six-bit brightness offset code.
// - 02H holds six-bit contrast code, nominal 26H.
// - 04H..06H hold six-bit channel gain codes, 3FH maximum.
// - 07H..09H hold full eight-bit black references.
// - Polarity 0: feedback reference follows black reference code.
// - Polarity 1: feedback reference held constant.
// - External reference outputs always follow 07H..09H.
// - Feedback references ignore the pedestal enable bit.
// - Pedestal enabled: ultra-black during output blanking.
// - Reset clears control and sets alignment codes to zero.
// - Pedestal enable also blanks during vertical retrace.
module vadj_top (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic        out_blank_in,
	input  wire logic        vert_blank_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	output logic [5:0]       brightness_out,
	output logic [5:0]       contrast_out,
	output logic [17:0]      gain_out,
	output logic [23:0]      black_ref_out,
	output logic [23:0]      feedback_ref_out,
	output logic             feedback_polarity_select_out,
	output logic             pedestal_blank_enable_out,
	output logic             ultra_black_out
);

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic       scl_prev;
	logic       sda_prev;

	// all four pins share one two-stage path, so the wires keep their order
	// blanking pins also start high; ultra black stays off since pedestal resets low
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			pin_meta <= 4'hF;
			pin_sync <= 4'hF;
		end else begin
			pin_meta <= {vert_blank_in, out_blank_in, sda_in, scl_in};
			pin_sync <= pin_meta;
		end
	end

	// idle bus is high on both wires, so reset to high avoids a false start
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			scl_prev <= 1'h1;
			sda_prev <= 1'h1;
		end else begin
			scl_prev <= pin_sync[0];
			sda_prev <= pin_sync[1];
		end
	end

	wire logic scl_s       = pin_sync[0];
	wire logic sda_s       = pin_sync[1];
	wire logic blank_s     = pin_sync[2];
	wire logic vblank_s    = pin_sync[3];
	wire logic scl_rise    = scl_s & ~scl_prev;
	wire logic scl_fall    = ~scl_s & scl_prev;
	wire logic start_det   = scl_s & scl_prev & sda_prev & ~sda_s;
	wire logic stop_det    = scl_s & scl_prev & ~sda_prev & sda_s;

	// ***************************************************************
	// byte engine state
	// ***************************************************************
	vadj_pkg::vadj_state_t state;
	vadj_pkg::vadj_state_t next_state;
	vadj_pkg::vadj_byte_t  byte_kind;
	logic [3:0]            bit_cnt;
	logic [7:0]            shift;
	logic [7:0]            sub_ptr;
	logic                  ack_high;

	// a byte ends on its eighth falling clock, while sda may still move
	wire logic byte_done   = (state == vadj_pkg::ST_RX) && (bit_cnt == vadj_pkg::BITS_PER_BYTE) &&
		scl_fall;
	wire logic ack_end     = (state == vadj_pkg::ST_ACK) && ack_high && scl_fall;
	wire logic sample_bit  = (state == vadj_pkg::ST_RX) && scl_rise &&
		(bit_cnt != vadj_pkg::BITS_PER_BYTE);
	wire logic is_addr     = (byte_kind == vadj_pkg::BYTE_ADDR);
	wire logic is_sub      = (byte_kind == vadj_pkg::BYTE_SUB);
	wire logic is_data     = (byte_kind == vadj_pkg::BYTE_DATA);

	wire logic addr_match  = (shift == {vadj_pkg::SLAVE_ADDR, vadj_pkg::DIR_WRITE});
	// only the auto-increment range moves or stores
	// 0AH to 0FH are acknowledged but stored nowhere, and the pointer stays put;
	// the test location is never implemented
	wire logic in_range    = (sub_ptr <= vadj_pkg::WRAP_LAST_OFS);
	wire logic at_last     = (sub_ptr == vadj_pkg::WRAP_LAST_OFS);
	wire logic [7:0] ptr_inc = 8'(sub_ptr + 8'h01);
	wire logic [7:0] next_ptr = at_last ? vadj_pkg::WRAP_FIRST_OFS : ptr_inc;

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		next_state = state;
		case (state)
			vadj_pkg::ST_IDLE: begin
				// stray clocks between frames are ignored until a start
				next_state = vadj_pkg::ST_IDLE;
			end
			vadj_pkg::ST_RX: begin
				if (byte_done) begin
					if (is_addr && !addr_match)
						next_state = vadj_pkg::ST_SKIP;
					else
						next_state = vadj_pkg::ST_ACK;
				end
			end
			vadj_pkg::ST_ACK: begin
				// leave on the ninth fall, once its rise has been seen
				if (ack_end)
					next_state = vadj_pkg::ST_RX;
			end
			vadj_pkg::ST_SKIP: begin
				// foreign frame: silent until the next start or stop
				next_state = vadj_pkg::ST_SKIP;
			end
			default: begin
				next_state = vadj_pkg::ST_IDLE;
			end
		endcase
		// a start or stop anywhere overrides the frame in progress
		if (start_det)
			next_state = vadj_pkg::ST_RX;
		else if (stop_det)
			next_state = vadj_pkg::ST_IDLE;
	end

	// reset lands in idle; the first frame needs a fresh start
	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			state <= vadj_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// ***************************************************************
	// bit shifter and counter
	// ***************************************************************
	// the counter stops at eight, so the ninth rise is never shifted in
	// sda is taken on the synchronised rise; both wires lag by the same two flops
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			bit_cnt <= 4'h0;
			shift   <= 8'h00;
		end else if (start_det || ack_end) begin
			bit_cnt <= 4'h0;
		end else if (sample_bit) begin
			bit_cnt <= 4'(bit_cnt + 4'h1);
			shift   <= {shift[6:0], sda_s};
		end
	end

	// which byte of the frame comes next; data repeats until stop
	// a repeated start begins again with the address byte
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || start_det)
			byte_kind <= vadj_pkg::BYTE_ADDR;
		else if (byte_done && is_addr)
			byte_kind <= vadj_pkg::BYTE_SUB;
		else if (byte_done && is_sub)
			byte_kind <= vadj_pkg::BYTE_DATA;
	end

	// remembers that the ninth clock went high before releasing sda
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || state != vadj_pkg::ST_ACK)
			ack_high <= 1'h0;
		else if (scl_rise)
			ack_high <= 1'h1;
	end

	// ***************************************************************
	// subaddress pointer
	// ***************************************************************
	// every subaddress byte reloads the pointer, even one out of range
	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			sub_ptr <= vadj_pkg::SUB_RESET;
		else if (byte_done && is_sub)
			sub_ptr <= shift;
		else if (byte_done && is_data && in_range)
			sub_ptr <= next_ptr;
	end

	// ***************************************************************
	// write strobe towards the bank
	// ***************************************************************
	// registered one cycle: the old address rides along while the pointer advances
	vadj_wr_if wr_bus ();

	logic       wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			wr_stb  <= 1'h0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			// out of range leaves every register alone
			wr_stb  <= byte_done && is_data && in_range;
			wr_addr <= sub_ptr;
			wr_data <= shift;
		end
	end

	assign wr_bus.wr_stb  = wr_stb;
	assign wr_bus.wr_addr = wr_addr;
	assign wr_bus.wr_data = wr_data;

	// ***************************************************************
	// acknowledge driver
	// ***************************************************************
	// pull sda low from the eighth falling clock until the ninth falls
	// a foreign address leaves sda alone, so another slave may answer
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || start_det || stop_det)
			sda_oe_out <= 1'h0;
		else if (byte_done && !(is_addr && !addr_match))
			sda_oe_out <= 1'h1;
		else if (ack_end)
			sda_oe_out <= 1'h0;
	end

	// open drain: the level driven is always low, only the enable moves
	// kept as a register so that every output leaves a flip-flop
	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			sda_out <= 1'h0;
		else
			sda_out <= 1'h0;
	end

	// ***************************************************************
	// register bank
	// ***************************************************************
	vadj_bank u_bank (
		.sys_clk_in                   (sys_clk_in),
		.rst_in                       (rst_in),
		.wr                           (wr_bus),
		.brightness_out               (brightness_out),
		.contrast_out                 (contrast_out),
		.gain_out                     (gain_out),
		.black_ref_out                (black_ref_out),
		.feedback_ref_out             (feedback_ref_out),
		.feedback_polarity_select_out (feedback_polarity_select_out),
		.pedestal_blank_enable_out    (pedestal_blank_enable_out)
	);

	// ***************************************************************
	// pedestal blanking
	// ***************************************************************
	// blanking pins are levels; a pulse shorter than one clock may be missed
	wire logic blank_any = blank_s | vblank_s;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			ultra_black_out <= 1'h0;
		else
			ultra_black_out <= pedestal_blank_enable_out & blank_any;
	end

endmodule

// >>> tb/vadj_master.sv
/*
 * vadj_master: behavioural two-wire bus master driving the device pins.
 * Assumes the bench resolves sda as open drain with a pull-up.
 */
`timescale 1ns/10ps
module vadj_master (
	output logic      scl_out,
	output logic      sda_drv_out,
	input  wire logic sda_in
);
	// bus clock stands high between frames
	initial begin
		scl_out = 1'h1;
		sda_drv_out = 1'h1;
	end

	task automatic put_bit(input logic b);
		#200 sda_drv_out = b;
		#200 scl_out = 1'h1;
		#400 scl_out = 1'h0;
	endtask

	// released sda floats to the pull-up level while the device answers
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) put_bit(b[i]);
		#200 sda_drv_out = 1'h1;
		#200 scl_out = 1'h1;
		#200 ack = ~sda_in;
		#200 scl_out = 1'h0;
	endtask

	task automatic xfer(input logic [7:0] q [$], output int acks);
		logic a;
		acks = 0;
		#200 sda_drv_out = 1'h0;
		#400 scl_out = 1'h0;
		foreach (q[i]) begin
			put_byte(q[i], a);
			acks += (a === 1'h1) ? 1 : 0;
		end
		#200 sda_drv_out = 1'h0;
		#200 scl_out = 1'h1;
		#400 sda_drv_out = 1'h1;
		#400;
	endtask
endmodule

// >>> tb/vadj_properties.sv
/*
 * vadj_properties: concurrent checks on the ports of vadj_top.
 * Assumes one clock domain and the synchronous active high reset.
 */
`timescale 1ns/10ps
module vadj_properties (
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        out_blank_in,
	input wire logic        vert_blank_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_out,
	input wire logic [5:0]  brightness_out,
	input wire logic [5:0]  contrast_out,
	input wire logic [17:0] gain_out,
	input wire logic [23:0] black_ref_out,
	input wire logic [23:0] feedback_ref_out,
	input wire logic        feedback_polarity_select_out,
	input wire logic        pedestal_blank_enable_out,
	input wire logic        ultra_black_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// ****************************************
	// assertions
	// ****************************************
	a_reset_clears: assert property ($fell(rst_in) |-> {brightness_out, contrast_out, gain_out,
		black_ref_out, feedback_polarity_select_out, pedestal_blank_enable_out} == '0)
		else $error("registers not cleared by reset");
	a_ack_low: assert property (sda_oe_out |-> !sda_out)
		else $error("acknowledge does not drive low");
	a_ack_length: assert property ($rose(sda_oe_out) |-> sda_oe_out[*4] ##[1:10] !sda_oe_out)
		else $error("acknowledge length wrong");
	a_write_in_ack: assert property (!$stable({brightness_out, contrast_out, gain_out,
		black_ref_out, pedestal_blank_enable_out}) |-> sda_oe_out)
		else $error("register changed outside an acknowledged byte");
	a_fb_follow: assert property ((!feedback_polarity_select_out && $stable(black_ref_out))[*3]
		|-> feedback_ref_out == black_ref_out) else $error("feedback not following code");
	a_fb_fixed: assert property (feedback_polarity_select_out[*3]
		|-> feedback_ref_out == {3{vadj_pkg::FEEDBACK_FIXED}}) else $error("feedback not fixed");
	a_ub_on: assert property ((pedestal_blank_enable_out && (out_blank_in || vert_blank_in))[*4]
		|-> ultra_black_out) else $error("ultra black missing");
	a_ub_off: assert property ((!pedestal_blank_enable_out || !(out_blank_in || vert_blank_in))[*4]
		|-> !ultra_black_out) else $error("ultra black unexpected");

	// ****************************************
	// covers
	// ****************************************
	c_ack: cover property ($rose(sda_oe_out));
	c_ub: cover property (ultra_black_out && vert_blank_in);
	c_ped_neg: cover property (!feedback_polarity_select_out && pedestal_blank_enable_out);
endmodule

bind vadj_top vadj_properties i_vadj_properties (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
	.out_blank_in(out_blank_in), .vert_blank_in(vert_blank_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .brightness_out(brightness_out), .contrast_out(contrast_out),
	.gain_out(gain_out), .black_ref_out(black_ref_out), .feedback_ref_out(feedback_ref_out),
	.feedback_polarity_select_out(feedback_polarity_select_out),
	.pedestal_blank_enable_out(pedestal_blank_enable_out), .ultra_black_out(ultra_black_out)
);

// >>> tb/video_adjust_i2c_slave_tb.sv
/*
 * video_adjust_i2c_slave_tb: writes register frames through the bus master model
 * and compares the adjustment outputs. Assumes a 10 MHz system clock.
 */
`timescale 1ns/10ps
module video_adjust_i2c_slave_tb;
	logic        sys_clk_in;
	logic        rst_in;
	logic        out_blank_in;
	logic        vert_blank_in;
	logic        scl;
	logic        sda_drv;
	logic        sda_out;
	logic        sda_oe_out;
	logic [5:0]  brightness_out;
	logic [5:0]  contrast_out;
	logic [17:0] gain_out;
	logic [23:0] black_ref_out;
	logic [23:0] feedback_ref_out;
	logic        pol;
	logic        ped;
	logic        ultra_black_out;
	logic        sda;
	logic [7:0]  fr [$];
	int          n_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;

	// open drain wire with pull-up
	assign sda = sda_drv & ~(sda_oe_out & ~sda_out);

	vadj_master i_vadj_master (.scl_out(scl), .sda_drv_out(sda_drv), .sda_in(sda));

	vadj_top i_vadj_top (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
		.out_blank_in(out_blank_in), .vert_blank_in(vert_blank_in), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .brightness_out(brightness_out), .contrast_out(contrast_out),
		.gain_out(gain_out), .black_ref_out(black_ref_out), .feedback_ref_out(feedback_ref_out),
		.feedback_polarity_select_out(pol), .pedestal_blank_enable_out(ped),
		.ultra_black_out(ultra_black_out)
	);

	initial begin
		sys_clk_in = 1'h0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	// ****************************************
	// checking helpers
	// ****************************************
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic send(input int exp_acks);
		int acks;
		// start off the sampling edge so the master never races the clock
		@(posedge sys_clk_in);
		#1 i_vadj_master.xfer(fr, acks);
		chk("acknowledge count", 24'(exp_acks), 24'(acks));
	endtask

	task automatic regs(input logic [5:0] b, input logic [17:0] g, input logic [23:0] k,
	                    input logic [23:0] f, input logic [1:0] ctl);
		chk("brightness", {18'h0, b}, {18'h0, brightness_out});
		chk("contrast", 24'h000026, {18'h0, contrast_out});
		chk("gain", {6'h0, g}, {6'h0, gain_out});
		chk("black reference", k, black_ref_out);
		chk("feedback reference", f, feedback_ref_out);
		chk("control", {22'h0, ctl}, {22'h0, pol, ped});
	endtask

	task automatic blank(input logic ob, input logic vb, input logic exp);
		out_blank_in <= ob;
		vert_blank_in <= vb;
		repeat (6) @(posedge sys_clk_in);
		#1 chk("ultra black", {23'h0, exp}, {23'h0, ultra_black_out});
	endtask

	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_in = 1'h1;
		out_blank_in = 1'h0;
		vert_blank_in = 1'h0;
		repeat (10) @(posedge sys_clk_in);
		#1 rst_in = 1'h0;
		chk("brightness", 24'h0, {18'h0, brightness_out});
		chk("black reference", 24'h0, black_ref_out);
		repeat (5) @(posedge sys_clk_in);
		// full sweep from 00H, through 09H, wrapping back onto 00H
		fr = {8'h88, 8'h00, 8'h09, 8'hFF, 8'h26, 8'h55, 8'h3F, 8'h15, 8'h2A,
			8'hA5, 8'h5A, 8'hFF, 8'h08};
		send(13);
		regs(6'h3F, {6'h2A, 6'h15, 6'h3F}, 24'hFF5AA5, 24'h808080, 2'b10);
		fr = {8'h88, 8'h00, 8'h00};
		send(3);
		regs(6'h3F, {6'h2A, 6'h15, 6'h3F}, 24'hFF5AA5, 24'hFF5AA5, 2'b00);
		fr = {8'h88, 8'h00, 8'h01};
		send(3);
		regs(6'h3F, {6'h2A, 6'h15, 6'h3F}, 24'hFF5AA5, 24'hFF5AA5, 2'b01);
		blank(1'h1, 1'h0, 1'h1);
		blank(1'h0, 1'h1, 1'h1);
		blank(1'h0, 1'h0, 1'h0);
		fr = {8'h88, 8'h00, 8'h00};
		send(3);
		blank(1'h1, 1'h1, 1'h0);
		// foreign address and read direction are not answered
		fr = {8'h8A, 8'h01, 8'h11};
		send(0);
		fr = {8'h89, 8'h01, 8'h11};
		send(0);
		// subaddress above the map: acknowledged, nothing stored
		fr = {8'h88, 8'h10, 8'h11, 8'h22};
		send(4);
		regs(6'h3F, {6'h2A, 6'h15, 6'h3F}, 24'hFF5AA5, 24'hFF5AA5, 2'b00);
		// one byte to the last channel, one wrapping onto 00H, so 0FH is never addressed
		fr = {8'h88, 8'h09, 8'h00, 8'h3F};
		send(4);
		// the wrap carries 3FH into control: polarity and pedestal both set
		regs(6'h3F, {6'h2A, 6'h15, 6'h3F}, 24'h005AA5, 24'h808080, 2'b11);
		// mid-run reset returns every register to zero
		@(posedge sys_clk_in);
		#1 rst_in = 1'h1;
		repeat (10) @(posedge sys_clk_in);
		#1 rst_in = 1'h0;
		chk("brightness", 24'h0, {18'h0, brightness_out});
		chk("contrast", 24'h0, {18'h0, contrast_out});
		chk("gain", 24'h0, {6'h0, gain_out});
		chk("black reference", 24'h0, black_ref_out);
		chk("feedback reference", 24'h0, feedback_ref_out);
		chk("control", 24'h0, {22'h0, pol, ped});
		chk("ultra black", 24'h0, {23'h0, ultra_black_out});
		// the bus still answers after the second reset
		repeat (5) @(posedge sys_clk_in);
		fr = {8'h88, 8'h02, 8'hE6};
		send(3);
		chk("contrast", 24'h000026, {18'h0, contrast_out});
		results();
	end
endmodule
